//--- pmv_core.sv
// Program store, program counter, vector selection and table-read path.
// Assumes the core supplies one-cycle interrupt events, enables, stack state,
// branch targets and table-read requests, all synchronous to i_sys_clk.
//
// Functional notes
// - Program store is 15 bits, 2K or 4K words
// - Reset loads program counter with 000H
// - First external interrupt vectors to 004H
// - Second external interrupt vectors to 008H
// - First timer overflow vectors to 00CH
// - Conversion complete vectors to 010H
// - Selected serial interface vectors to 014H
// - Shared multi-function sources vector to 018H
// - Table address low byte from pointer
// - Upper bits: current page or all ones
// - Low byte to register, high to latch
// - Unused latch bit 7 reads as zero
// - Table address 12 or 11 bits wide
// - 2K last page starts at 700H
// - Latch read-only, held until next read
// - Table read lasts exactly two cycles
// - Stack full: record request, defer vectoring
// - Program counter 12 or 11 bits
`default_nettype none
module pmv_core
  import pmv_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_4K
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_step,
  input wire logic i_branch_en,
  input wire logic [ADDR_W-1:0] i_branch_addr,
  input wire logic [NUM_IRQ-1:0] i_irq_evt,
  input wire logic [NUM_IRQ-1:0] i_irq_en,
  input wire logic i_stack_full,
  input wire pmv_tab_req_s i_tab_req,
  input wire logic i_prog_we,
  input wire logic [ADDR_W-1:0] i_prog_addr,
  input wire logic [PROG_W-1:0] i_prog_data,
  output logic [ADDR_W-1:0] o_pc,
  output logic [PROG_W-1:0] o_instr,
  output logic o_vec_take,
  output logic [NUM_IRQ-1:0] o_irq_ack,
  output logic [NUM_IRQ-1:0] o_irq_pending,
  output logic o_tab_busy,
  output pmv_dm_wr_s o_dm_wr,
  output logic [BYTE_W-1:0] o_table_high_latch
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PAGE_W = ADDR_W - BYTE_W;

  // Program store array
  logic [PROG_W-1:0] prog_mem [DEPTH];

  logic [ADDR_W-1:0] pc_ff;
  logic [ADDR_W-1:0] nxt_pc;
  logic [PROG_W-1:0] instr_ff;
  logic [NUM_IRQ-1:0] pend_ff;
  logic [NUM_IRQ-1:0] ack_ff;
  logic take_ff;
  pmv_trd_e state_ff;
  pmv_trd_e nxt_state;
  logic [ADDR_W-1:0] tab_addr_ff;
  logic busy_ff;
  logic [BYTE_W-1:0] dst_ff;
  pmv_dm_wr_s dm_wr_ff;
  logic [BYTE_W-1:0] latch_ff;

  // Request decode and vector choice
  // A table start or a read in progress holds off vectoring, so the
  // pushed return address is never taken from the middle of a table read
  wire tab_start = (state_ff == PMV_IDLE) && (i_tab_req.cur_page || i_tab_req.last_page);
  wire tab_busy = (state_ff != PMV_IDLE);
  wire [NUM_IRQ-1:0] serviceable = pend_ff & i_irq_en;
  wire can_vector = !i_stack_full && !tab_busy && !tab_start;
  logic [VEC_IDX_W-1:0] win_idx;
  logic [NUM_IRQ-1:0] win_hot;
  wire vec_take = can_vector && (serviceable != '0);
  wire [11:0] vec_full = VEC_TABLE[win_idx*12 +: 12];
  wire [ADDR_W-1:0] vec_addr = vec_full[ADDR_W-1:0];
  wire [ADDR_W-1:0] reset_pc = RESET_PC[ADDR_W-1:0];

  // Table address: pointer low, page bits from PC or forced high
  // Last page wins if both page kinds are asked for at once
  wire [PAGE_W-1:0] page_bits = i_tab_req.last_page ? {PAGE_W{1'b1}} : pc_ff[ADDR_W-1:BYTE_W];
  wire [ADDR_W-1:0] tab_addr = {page_bits, i_tab_req.ptr};

  // Lowest-index pending and enabled source wins
  // Scanned from the top so the last hit, the lowest index, is kept
  always_comb begin
    win_idx = '0;
    win_hot = '0;
    for (int k = NUM_IRQ - 1; k >= 0; k--) begin
      if (serviceable[k]) begin
        win_idx = VEC_IDX_W'(k);
        win_hot = NUM_IRQ'(1) << k;
      end
    end
  end

  // Program counter next value
  // Order of precedence: vector, then branch, then step
  // Branch and step are refused in a table start cycle and while busy,
  // which is what stretches a table read to two instruction cycles
  always_comb begin
    nxt_pc = pc_ff;
    if (vec_take) begin
      nxt_pc = vec_addr;
    end else if (!tab_busy && !tab_start && i_branch_en) begin
      nxt_pc = i_branch_addr;
    end else if (!tab_busy && !tab_start && i_step) begin
      nxt_pc = pc_ff + ADDR_W'(1);
    end
  end

  // Table-read sequencer
  // Gray codes along idle, first, second; the spare code falls back to idle
  always_comb begin
    case (state_ff)
      PMV_IDLE: nxt_state = tab_start ? PMV_TRD1 : PMV_IDLE;
      PMV_TRD1: nxt_state = PMV_TRD2;
      PMV_TRD2: nxt_state = PMV_IDLE;
      default: nxt_state = PMV_IDLE;
    endcase
  end

  // Store write path and instruction fetch
  // The store itself has no reset: it keeps what the loader wrote
  // Fetch has one cycle of latency behind the program counter
  always_ff @(posedge i_sys_clk) begin
    if (i_prog_we) begin
      prog_mem[i_prog_addr] <= i_prog_data;
    end
    instr_ff <= prog_mem[pc_ff];
  end

  // Program counter and vector acknowledge
  // Acknowledge is a one-cycle pulse beside the vector in the counter
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pc_ff <= reset_pc;
      take_ff <= 1'b0;
      ack_ff <= '0;
    end else begin
      pc_ff <= nxt_pc;
      take_ff <= vec_take;
      ack_ff <= vec_take ? win_hot : '0;
    end
  end

  // Pending flags: a new event beats the clear of the served bit
  // Flags record every event; enables only gate service, so a masked
  // source is still waiting when its enable comes back
  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_pend
    always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
        pend_ff[g] <= 1'b0;
      end else if (i_irq_evt[g]) begin
        pend_ff[g] <= 1'b1;
      end else if (vec_take && win_hot[g]) begin
        pend_ff[g] <= 1'b0;
      end
    end
  end

  // Table-read state, address capture and result delivery
  // The word is read in the first busy cycle and delivered in the second;
  // the latch then holds until the next table read replaces it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_ff <= PMV_IDLE;
      busy_ff <= 1'b0;
      tab_addr_ff <= '0;
      dst_ff <= '0;
      dm_wr_ff <= '0;
      latch_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != PMV_IDLE);
      dm_wr_ff.en <= 1'b0;
      if (tab_start) begin
        tab_addr_ff <= tab_addr;
        dst_ff <= i_tab_req.dst;
      end
      if (state_ff == PMV_TRD1) begin
        dm_wr_ff.en <= 1'b1;
        dm_wr_ff.addr <= dst_ff;
        dm_wr_ff.data <= prog_mem[tab_addr_ff][BYTE_W-1:0];
        latch_ff <= {1'b0, prog_mem[tab_addr_ff][PROG_W-1:BYTE_W]};
      end
    end
  end

  // Outputs straight from flip-flops
  // Busy is its own flop so that the pin is not a decode of the state
  assign o_pc = pc_ff;
  assign o_instr = instr_ff;
  assign o_vec_take = take_ff;
  assign o_irq_ack = ack_ff;
  assign o_irq_pending = pend_ff;
  assign o_tab_busy = busy_ff;
  assign o_dm_wr = dm_wr_ff;
  assign o_table_high_latch = latch_ff;

  // Checks: one clock domain, idle while reset is held except the reset checks below
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // Table read: the accepted start, then two busy cycles and a release
  sequence s_start;
    tab_start;
  endsequence
  sequence s_two_busy;
    o_tab_busy [*2] ##1 !o_tab_busy;
  endsequence
  // Low byte write shows two cycles after the start, for one cycle only
  sequence s_write_pulse;
    ##2 o_dm_wr.en ##1 !o_dm_wr.en;
  endsequence
  // A vector is taken this cycle
  sequence s_vec;
    vec_take;
  endsequence

  // Reset is watched while it is held, so these opt out of the default disable
  reset_pc_a: assert property (disable iff (1'b0) !i_rst_b |=> o_pc == reset_pc)
    else $error("pc not zero after reset");
  reset_clr_a: assert property (disable iff (1'b0) !i_rst_b |=> o_irq_pending == '0)
    else $error("pending flags survive reset");
  reset_busy_a: assert property (disable iff (1'b0) !i_rst_b |=> !o_tab_busy)
    else $error("table read survives reset");
  reset_latch_a: assert property (disable iff (1'b0) !i_rst_b |=> o_table_high_latch == '0)
    else $error("latch not cleared by reset");

  // Vector addresses, one check per source
  vec_target_a: assert property (vec_take |=> o_pc == $past(vec_addr) && o_vec_take)
    else $error("vector target wrong");
  vec_first_a: assert property (vec_take && win_hot[0] |-> vec_full == 12'h004)
    else $error("first external vector wrong");
  vec_second_a: assert property (vec_take && win_hot[1] |-> vec_full == 12'h008)
    else $error("second external vector wrong");
  vec_timer_a: assert property (vec_take && win_hot[2] |-> vec_full == 12'h00c)
    else $error("timer vector wrong");
  vec_conv_a: assert property (vec_take && win_hot[3] |-> vec_full == 12'h010)
    else $error("conversion vector wrong");
  vec_serial_a: assert property (vec_take && win_hot[4] |-> vec_full == 12'h014)
    else $error("serial vector wrong");
  vec_code_a: assert property (vec_take && win_hot[5] |-> vec_full == 12'h018)
    else $error("shared vector address wrong");
  vec_enabled_a: assert property (vec_take |-> (win_hot & i_irq_en) != '0)
    else $error("disabled source vectored");

  // Acknowledge pulse pairs with the vector and names one source
  ack_onehot_a: assert property (o_vec_take |-> $onehot(o_irq_ack))
    else $error("acknowledge not one-hot");
  ack_quiet_a: assert property (!o_vec_take |-> o_irq_ack == '0)
    else $error("acknowledge without vector");
  take_pulse_a: assert property (s_vec |=> o_irq_ack == $past(win_hot))
    else $error("acknowledge names wrong source");
  win_onehot_a: assert property (vec_take |-> $onehot(win_hot))
    else $error("more than one winner");
  prio_low_a: assert property (vec_take |-> (serviceable & (win_hot - 1'b1)) == '0)
    else $error("lower vector skipped");

  // Pending flags: set by events, kept while refused, cleared on service
  stack_hold_a: assert property (i_stack_full |=> !o_vec_take)
    else $error("vectored with stack full");
  take_stack_a: assert property (o_vec_take |-> !$past(i_stack_full))
    else $error("vector taken over full stack");
  busy_hold_a: assert property (tab_busy |=> !o_vec_take)
    else $error("vectored during table read");
  pend_set_a: assert property ((i_irq_evt != '0)
    |=> (o_irq_pending & $past(i_irq_evt)) == $past(i_irq_evt))
    else $error("event not recorded");
  pend_keep_a: assert property (!vec_take && (i_irq_evt == '0)
    |=> o_irq_pending == $past(o_irq_pending))
    else $error("pending flag lost");
  pend_clear_a: assert property (vec_take && ((i_irq_evt & win_hot) == '0)
    |=> (o_irq_pending & $past(win_hot)) == '0)
    else $error("served flag not cleared");
  stack_keep_a: assert property (i_stack_full && |pend_ff |=> |o_irq_pending)
    else $error("request dropped while stack full");

  // Program counter: branch and step only outside table reads
  pc_hold_a: assert property (tab_start || tab_busy |=> $stable(o_pc))
    else $error("pc moved during table read");
  branch_load_a: assert property (!vec_take && !tab_start && !tab_busy && i_branch_en
    |=> o_pc == $past(i_branch_addr))
    else $error("branch target not loaded");
  step_inc_a: assert property (!vec_take && !tab_start && !tab_busy
    && !i_branch_en && i_step |=> o_pc == $past(o_pc) + 1'b1)
    else $error("step did not advance pc");
  fetch_a: assert property (1'b1 |=> o_instr == $past(prog_mem[o_pc]))
    else $error("fetched word wrong");

  // Table read: address forming, result delivery and latch behaviour
  trd_len_a: assert property (s_start |=> s_two_busy)
    else $error("table read not two cycles");
  trd_write_a: assert property (s_start |-> s_write_pulse)
    else $error("low byte write timing wrong");
  trd_en_busy_a: assert property (o_dm_wr.en |-> o_tab_busy)
    else $error("write outside table read");
  busy_match_a: assert property (o_tab_busy == tab_busy)
    else $error("busy pin disagrees with state");
  addr_hold_a: assert property (tab_busy |=> $stable(tab_addr_ff))
    else $error("table address moved while busy");
  last_page_a: assert property (tab_start && i_tab_req.last_page
    |=> tab_addr_ff[ADDR_W-1:BYTE_W] == {PAGE_W{1'b1}})
    else $error("last page bits not ones");
  cur_page_a: assert property (tab_start && !i_tab_req.last_page
    |=> tab_addr_ff[ADDR_W-1:BYTE_W] == $past(pc_ff[ADDR_W-1:BYTE_W]))
    else $error("current page bits wrong");
  ptr_low_a: assert property (tab_start
    |=> tab_addr_ff[BYTE_W-1:0] == $past(i_tab_req.ptr))
    else $error("pointer not used as low byte");
  wr_dst_a: assert property (s_start
    |-> ##2 o_dm_wr.addr == $past(i_tab_req.dst, 2))
    else $error("low byte sent to wrong register");
  wr_low_a: assert property (o_dm_wr.en
    |-> o_dm_wr.data == $past(prog_mem[tab_addr_ff][BYTE_W-1:0]))
    else $error("low byte wrong");
  latch_load_a: assert property (o_dm_wr.en
    |-> o_table_high_latch[HIGH_W-1:0] == $past(prog_mem[tab_addr_ff][PROG_W-1:BYTE_W]))
    else $error("high part wrong");
  wr_pulse_a: assert property (o_dm_wr.en |=> !o_dm_wr.en)
    else $error("write pulse too long");
  latch_hold_a: assert property (!o_dm_wr.en |-> $stable(o_table_high_latch) or $rose(o_dm_wr.en))
    else $error("latch changed without table read");
  latch_msb_a: assert property (o_table_high_latch[BYTE_W-1] == 1'b0)
    else $error("unused latch bit set");
endmodule
`default_nettype wire

//--- pmv_pkg.sv
// Constants and carrier types for the program memory, vector and table-read block.
// Assumes one system clock at 50 MHz and a synchronous active-low reset.
`default_nettype none
package pmv_pkg;
  // Program word and data widths
  localparam int PROG_W = 15;
  localparam int BYTE_W = 8;
  localparam int HIGH_W = PROG_W - BYTE_W;
  localparam int ADDR_W_4K = 12;
  localparam int ADDR_W_2K = 11;
  localparam int NUM_IRQ = 6;
  localparam int VEC_IDX_W = 3;

  // Reset value of the program counter
  localparam logic [11:0] RESET_PC = 12'h000;

  // Fixed interrupt entry points, lowest address first
  localparam logic [11:0] VEC_EXT_FIRST = 12'h004;
  localparam logic [11:0] VEC_EXT_SECOND = 12'h008;
  localparam logic [11:0] VEC_TIMER0 = 12'h00c;
  localparam logic [11:0] VEC_ADC = 12'h010;
  localparam logic [11:0] VEC_SERIAL = 12'h014;
  localparam logic [11:0] VEC_MULTI = 12'h018;
  localparam logic [NUM_IRQ*12-1:0] VEC_TABLE = {VEC_MULTI, VEC_SERIAL, VEC_ADC,
                                                  VEC_TIMER0, VEC_EXT_SECOND, VEC_EXT_FIRST};

  // Table-read sequencer states, Gray along idle -> first -> second
  typedef enum logic [1:0] {
    PMV_IDLE = 2'b00,
    PMV_TRD1 = 2'b01,
    PMV_TRD2 = 2'b11
  } pmv_trd_e;

  // Table-read request from the execute logic
  typedef struct packed {
    logic cur_page;
    logic last_page;
    logic [BYTE_W-1:0] ptr;
    logic [BYTE_W-1:0] dst;
  } pmv_tab_req_s;

  // Write of the low table byte into a data memory register
  typedef struct packed {
    logic en;
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } pmv_dm_wr_s;
endpackage
`default_nettype wire

//--- pmv_img_model.sv
// Far-side model: the core's loader that writes a known image into the program store.
// Assumes the same clock and synchronous active-low reset as the block under test.
`default_nettype none
module pmv_img_model
  import pmv_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  output logic o_prog_we,
  output logic [ADDR_W_2K-1:0] o_prog_addr,
  output logic [PROG_W-1:0] o_prog_data,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W_2K:0] cnt_ff;
  // One word per cycle, every page gets a distinct pattern; idle data toggles
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_ff <= '0;
      o_prog_we <= 1'b0;
      o_prog_addr <= '0;
      o_prog_data <= '0;
    end else begin
      o_prog_we <= !cnt_ff[ADDR_W_2K];
      o_prog_addr <= cnt_ff[ADDR_W_2K-1:0];
      o_prog_data <= cnt_ff[ADDR_W_2K] ? ~o_prog_data :
                     {cnt_ff[10:4], cnt_ff[7:0] ^ {5'h00, cnt_ff[10:8]}};
      if (!cnt_ff[ADDR_W_2K]) cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign o_done = cnt_ff[ADDR_W_2K] & !o_prog_we;
endmodule
`default_nettype wire

//--- test_pmv_core.sv
// Testbench for the 2K program store, vectors and table reads.
// Assumes the loader model fills the image before any scenario starts.
`default_nettype none
module test_pmv_core
  import pmv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, step, br_en, full, pwe, vt, busy, done;
  logic [10:0] br_addr, paddr, pc;
  logic [5:0] evt, en, ack, pend;
  logic [14:0] pdata, instr;
  logic [7:0] latch;
  pmv_tab_req_s req;
  pmv_dm_wr_s dmw;
  int fail_count = 0, checks = 0, cyc = 0, k;
  pmv_core #(.ADDR_W(11)) i_pmv_core (.i_sys_clk(clk), .i_rst_b(rst_b), .i_step(step),
    .i_branch_en(br_en), .i_branch_addr(br_addr), .i_irq_evt(evt), .i_irq_en(en),
    .i_stack_full(full), .i_tab_req(req), .i_prog_we(pwe), .i_prog_addr(paddr),
    .i_prog_data(pdata), .o_pc(pc), .o_instr(instr), .o_vec_take(vt), .o_irq_ack(ack),
    .o_irq_pending(pend), .o_tab_busy(busy), .o_dm_wr(dmw), .o_table_high_latch(latch));
  pmv_img_model i_pmv_img_model (.i_sys_clk(clk), .i_rst_b(rst_b), .o_prog_we(pwe),
    .o_prog_addr(paddr), .o_prog_data(pdata), .o_done(done));
  // Image word expected at each address
  function automatic logic [14:0] w(input logic [10:0] a);
    return {a[10:4], a[7:0] ^ {5'h00, a[10:8]}};
  endfunction
  task automatic chk(input string m, input logic [14:0] got, input logic [14:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_vt();
    for (k = 0; k < 8 && vt !== 1'b1; k++) @(negedge clk);
  endtask
  // Pulse one or more sources for a single cycle
  task automatic pulse(input logic [5:0] s);
    @(negedge clk) evt = s;
    @(negedge clk) evt = '0;
  endtask
  task automatic t_vec();
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i);
      wait_vt();
      chk("vector address", 15'(pc), 15'((i + 1) * 4));
      chk("ack", 15'(ack), 15'(6'h01 << i));
    end
  endtask
  task automatic t_full();
    full = 1'b1;
    pulse(6'h01);
    repeat (4) @(negedge clk);
    chk("pending kept", 15'(pend), 15'h0001);
    chk("no vector", 15'(vt), 15'h0000);
    full = 1'b0;
    @(negedge clk) wait_vt();
    chk("deferred vector", 15'(pc), 15'h0004);
  endtask
  task automatic t_prio();
    pulse(6'h22);
    wait_vt();
    chk("low first", 15'(ack), 15'h0002);
    @(negedge clk) wait_vt();
    chk("then shared", 15'(pc), 15'h0018);
  endtask
  task automatic t_tab(input logic last, input logic [7:0] ptr, input logic [10:0] a);
    logic [14:0] e;
    e = w(a);
    @(negedge clk) req = '{cur_page: !last, last_page: last, ptr: ptr, dst: ~ptr};
    @(negedge clk) req = '0;
    chk("busy 1st", 15'({busy, 6'h00, dmw.en}), 15'h0080);
    @(negedge clk);
    chk("busy 2nd", 15'({busy, 6'h00, dmw.en}), 15'h0081);
    chk("low byte", {dmw.addr[6:0], dmw.data}, {~ptr[6:0], e[7:0]});
    chk("latch", 15'(latch), 15'({1'b0, e[14:8]}));
    @(negedge clk);
    chk("done", 15'({busy, 6'h00, dmw.en}), 15'h0000);
    repeat (5) @(negedge clk);
    chk("latch held", 15'(latch), 15'({1'b0, e[14:8]}));
  endtask
  task automatic t_page();
    @(negedge clk) {br_en, br_addr} = {1'b1, 11'h3a0};
    @(negedge clk) br_en = 1'b0;
    @(negedge clk);
    chk("fetch", instr, w(11'h3a0));
    t_tab(1'b0, 8'h11, 11'h311);
    chk("pc held", 15'(pc), 15'h03a0);
  endtask
  // Three steps from the branch target
  task automatic t_step();
    @(negedge clk) step = 1'b1;
    repeat (3) @(negedge clk);
    step = 1'b0;
    chk("step", 15'(pc), 15'h03a3);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    {rst_b, step, br_en, full, br_addr, evt, req} = '0;
    en = 6'h3f;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    chk("reset pc", 15'(pc), 15'h0000);
    chk("reset latch", {busy, 6'h00, latch}, 15'h0000);
    for (k = 0; k < 2100 && done !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    chk("first word", instr, w(11'h000));
    t_vec();
    t_full();
    t_prio();
    t_tab(1'b1, 8'h06, 11'h706);
    t_tab(1'b1, 8'h05, 11'h705);
    t_page();
    t_step();
    rst_b = 1'b0;
    @(negedge clk);
    chk("second reset", {pc, latch[3:0]}, 15'h0000);
    rst_b = 1'b1;
    @(negedge clk);
    chk("after release", {pc, busy, latch[2:0]}, 15'h0000);
    final_report();
  end
endmodule
`default_nettype wire
